// >>> iwl_top.sv
// Top: timer and supply-monitor flags, group interrupt entry, wake-up, AXI4-Lite registers
module iwl_top (
  input wire logic ref_clk, // 10 MHz clock, kept running in sleep for the flag logic
  input wire logic rst, // Synchronous reset, active high
  input wire logic [iwl_pkg::NUM_TM-1:0] period_match, // Comparator P match pulses
  input wire logic [iwl_pkg::NUM_TM-1:0] compare_a_match, // Comparator A match pulses
  input wire logic supply_low_raw, // Analog comparator output, asynchronous
  input wire iwl_pkg::iwl_core_req_s core_req, // Sequencer requests
  output iwl_pkg::iwl_core_ans_s core_ans, // Vector call and push
  output logic wake_up, // One-cycle wake request
  output logic monitor_on, // Detector analog enable
  output logic [2:0] threshold_sel, // Trip level select
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read response valid
  input wire logic s_axi_rready // Read response ready
);
  import iwl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [NUM_TM-1:0] period_match_request_flag;
  logic [NUM_TM-1:0] compare_a_match_request_flag;
  logic [NUM_TM-1:0] period_match_irq_enable;
  logic [NUM_TM-1:0] compare_a_match_irq_enable;
  logic global_irq_enable;
  logic group_irq_enable;
  logic group_request_flag;
  logic mon_irq_enable;
  logic supply_monitor_request_flag;
  logic [2:0] low_sync;
  logic detector_output_bit;
  logic det_prev;
  logic [9:0] delay_cnt;
  logic delay_run;
  logic [9:0] stab_cnt;
  logic [NUM_FLAG-1:0] flags_prev;
  logic [NUM_FLAG-1:0] flags_now;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  iwl_rd_e rd_state;
  logic any_src_req;
  logic [NUM_FLAG-1:0] src_en;
  logic [NUM_FLAG-1:0] src_prev;
  logic ctrl_wr;
  logic entry;

  // Write to one byte lane when its strobe is set
  function automatic logic lane(input logic [3:0] strb, input logic [7:0] addr, input logic [7:0] target);
    lane = strb[0] && (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken independently, response after both
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= REG_STATUS && aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply-monitor control fields and enables
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      monitor_on <= SUPPLY_MON_RESET[MON_EN_BIT];
      threshold_sel <= SUPPLY_MON_RESET[THR_LSB+:3];
      period_match_irq_enable <= '0;
      compare_a_match_irq_enable <= '0;
      group_irq_enable <= 1'b0;
      mon_irq_enable <= 1'b0;
    end else if (wr_fire) begin
      if (lane(w_strb, aw_addr, REG_SUPPLY_MON)) begin
        monitor_on <= w_data[MON_EN_BIT]; // [R11]
        threshold_sel <= w_data[THR_LSB+:3]; // [R10]
      end
      if (lane(w_strb, aw_addr, REG_TM_ENABLES)) begin
        period_match_irq_enable <= w_data[NUM_TM-1:0]; // [R1]
        compare_a_match_irq_enable <= w_data[4+:NUM_TM];
      end
      if (lane(w_strb, aw_addr, REG_CORE_CTRL)) begin
        group_irq_enable <= w_data[GRP_EN_BIT];
        mon_irq_enable <= w_data[MON_IE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer flags: match sets, software write of 0 clears, set wins the tie
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      period_match_request_flag <= '0;
      compare_a_match_request_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_TM; i++) begin
        if (period_match[i]) begin
          period_match_request_flag[i] <= 1'b1; // [R2]
        end else if (wr_fire && lane(w_strb, aw_addr, REG_TM_FLAGS)) begin
          period_match_request_flag[i] <= w_data[i]; // [R7]
        end
        if (compare_a_match[i]) begin
          compare_a_match_request_flag[i] <= 1'b1; // [R2]
        end else if (wr_fire && lane(w_strb, aw_addr, REG_TM_FLAGS)) begin
          compare_a_match_request_flag[i] <= w_data[4+i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector input synchroniser; second and third stages agree before a change counts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_sync <= 3'b000;
      detector_output_bit <= 1'b0;
      det_prev <= 1'b0;
    end else begin
      low_sync <= {low_sync[1:0], supply_low_raw};
      if (!monitor_on) begin
        detector_output_bit <= 1'b0;
      end else if (low_sync[1] == low_sync[2]) begin
        detector_output_bit <= low_sync[2]; // [R12] [R18]
      end
      det_prev <= detector_output_bit;
    end
  end

  // Flag delay after each rise; a fall cancels the wait and the next rise restarts it so every toggle is seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      delay_cnt <= 10'h000;
      delay_run <= 1'b0;
      stab_cnt <= 10'h000;
    end else begin
      stab_cnt <= !monitor_on ? STAB_CNT : (stab_cnt != 10'h000 ? stab_cnt - 10'h001 : 10'h000); // [R19]
      if (detector_output_bit && !det_prev) begin
        delay_run <= 1'b1; // [R14] [R18]
        delay_cnt <= FLAG_SET_CNT;
      end else if (!detector_output_bit) begin
        delay_run <= 1'b0;
      end else if (delay_run && delay_cnt != 10'h000) begin
        delay_cnt <= delay_cnt - 10'h001; // [R19]
      end else begin
        delay_run <= 1'b0;
      end
    end
  end

  // Monitor flag: set after the delay even in sleep; software clears, set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supply_monitor_request_flag <= 1'b0;
    end else if (delay_run && delay_cnt == 10'h001 && detector_output_bit) begin
      supply_monitor_request_flag <= 1'b1; // [R14] [R15]
    end else if (wr_fire && lane(w_strb, aw_addr, REG_CORE_CTRL)) begin
      supply_monitor_request_flag <= w_data[MON_FLAG_BIT]; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Group entry and return handling
  // Group flag arms on a new enabled request only; a source left pending cannot re-arm it after entry
  assign src_en = {mon_irq_enable, compare_a_match_irq_enable, period_match_irq_enable};
  assign any_src_req = |(flags_now & src_en & ~src_prev);
  assign entry = core_req.service && global_irq_enable && group_irq_enable && group_request_flag &&
                 !core_req.stack_full; // [R3]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      group_request_flag <= 1'b0;
      global_irq_enable <= 1'b0;
      core_ans <= '0;
      src_prev <= '0;
    end else begin
      src_prev <= flags_now & src_en;
      core_ans.vector_call <= entry;
      core_ans.push_pc <= entry; // [R8] only the PC is pushed
      if (any_src_req) begin
        group_request_flag <= 1'b1;
      end else if (entry) begin
        group_request_flag <= 1'b0; // [R4]
      end
      if (entry) begin
        global_irq_enable <= 1'b0; // [R4]
      end else if (core_req.return_from_interrupt_instr) begin
        global_irq_enable <= 1'b1; // [R9]
      end else if (wr_fire && lane(w_strb, aw_addr, REG_CORE_CTRL)) begin
        global_irq_enable <= w_data[GIE_BIT]; // Software write; a plain return changes nothing [R9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up in sleep: OR of rising edges of every flag, enables not consulted
  assign flags_now = {supply_monitor_request_flag, compare_a_match_request_flag, period_match_request_flag};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_prev <= '0;
      wake_up <= 1'b0;
    end else begin
      flags_prev <= flags_now;
      wake_up <= core_req.sleep && |(flags_now & ~flags_prev); // [R5] [R6] [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read, one cycle to data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_state <= IWL_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        IWL_RD_IDLE: begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            rd_state <= IWL_RD_RESP;
            case (s_axi_araddr)
              REG_SUPPLY_MON: s_axi_rdata <= {26'h0, detector_output_bit, monitor_on, 1'b0, threshold_sel}; // [R13]
              REG_TM_FLAGS: s_axi_rdata <= {24'h0, compare_a_match_request_flag, period_match_request_flag};
              REG_TM_ENABLES: s_axi_rdata <= {24'h0, compare_a_match_irq_enable, period_match_irq_enable};
              REG_CORE_CTRL: s_axi_rdata <= {28'h0, supply_monitor_request_flag, mon_irq_enable,
                                             group_irq_enable, global_irq_enable};
              REG_STATUS: s_axi_rdata <= {30'h0, stab_cnt == 10'h000, group_request_flag}; // [R16]
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
              end
            endcase
          end
        end
        IWL_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= IWL_RD_IDLE;
          end
        end
        default: rd_state <= IWL_RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks; software writes of the control word are excluded where they may legally move the bit
  assign ctrl_wr = wr_fire && lane(w_strb, aw_addr, REG_CORE_CTRL);
  chk_entry_clears_gie: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
    entry |=> !global_irq_enable && core_ans.vector_call) else $error("entry did not clear enable");
  chk_entry_clears_group: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
    entry && !any_src_req |=> !group_request_flag) else $error("group flag kept after entry");
  chk_entry_needs_all: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    core_ans.vector_call |-> $past(global_irq_enable) && $past(group_irq_enable) && $past(group_request_flag) &&
    !$past(core_req.stack_full)) else $error("vector without enables");
  chk_return_from_interrupt_instr_sets_gie: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
    core_req.return_from_interrupt_instr && !entry |=> global_irq_enable) else $error("return did not set enable");
  chk_ret_keeps_gie: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
    core_req.ret && !core_req.return_from_interrupt_instr && !global_irq_enable && !ctrl_wr |=> !global_irq_enable)
    else $error("plain return set enable");
  chk_match_sets_flag: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
    period_match[0] |=> period_match_request_flag[0]) else $error("match lost");
  chk_flag_holds_set: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    period_match_request_flag[0] && !(wr_fire && lane(w_strb, aw_addr, REG_TM_FLAGS))
    |=> period_match_request_flag[0]) else $error("flag dropped");
  chk_wake_on_rise: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    core_req.sleep && $rose(compare_a_match_request_flag[0]) |=> wake_up) else $error("no wake");
  chk_no_wake_high: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
    wake_up |-> $past(core_req.sleep) && (($past(flags_now) & ~$past(flags_prev)) != '0))
    else $error("spurious wake");
  chk_mon_flag_delay: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    $rose(supply_monitor_request_flag) && !$past(ctrl_wr) |-> $past(delay_run) && $past(detector_output_bit))
    else $error("monitor flag early");
  chk_det_off: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    !monitor_on |=> !detector_output_bit) else $error("detector on while disabled");
endmodule

// >>> iwl_pkg.sv
// Package: register map, field layout, timing constants and carriers for the interrupt/wake/supply-monitor block
// Operation
// R1: Each timer module has period and compare-A flags with enables, grouped under a group interrupt.
// R2: A comparator P or A match event sets the matching timer flag.
// R3: Vector call needs global, source and group enables, stack not full and a flag.
// R4: On service, clear global enable and group flag; keep source flags for software.
// R5: In sleep or idle, any flag rising from low to high raises a wake-up.
// R6: Wake-up ignores enables; a flag already high before sleep gives no wake-up.
// R7: Flags stay set until serviced or cleared; enables only block servicing.
// R8: Interrupt entry pushes only the program counter onto the stack.
// R9: Return-from-interrupt sets global enable; plain return leaves it cleared.
// R10: Three-bit threshold field in bits 2..0 selects one of eight trip levels.
// R11: Monitor enable at bit 4 turns the detector on when set.
// R12: Detector output at bit 5 reads 1 while supply is below the threshold.
// R13: Bits 7, 6 and 3 of the supply-monitor register read as zero.
// R14: Supply-monitor flag sets only after a fixed delay following detector output rise.
// R15: With monitor enabled, detector runs in power-down and its flag wakes the device.
// R16: Software waits a stabilisation delay after enabling before trusting the output bit.
// R17: Software clears the supply-monitor flag before enabling its interrupt.
// R18: Repeated detector output toggles are accepted without filtering; the code holds a change until synchroniser stages two and three agree.
// R19: Flag delay and stabilisation delay are cycle counts on an always-on clock.
// R20: Wake-up is the OR of one-cycle rising-edge detects on every request flag.
package iwl_pkg;
  localparam int NUM_TM = 4;
  localparam int NUM_FLAG = 2 * NUM_TM + 1;
  // Byte addresses of the AXI4-Lite register words
  localparam logic [7:0] REG_SUPPLY_MON = 8'h00;
  localparam logic [7:0] REG_TM_FLAGS = 8'h04;
  localparam logic [7:0] REG_TM_ENABLES = 8'h08;
  localparam logic [7:0] REG_CORE_CTRL = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Supply-monitor field positions
  localparam int THR_LSB = 0;
  localparam int MON_EN_BIT = 4;
  localparam int DET_OUT_BIT = 5;
  // Core control word: bit 0 global enable, bit 1 group enable, bit 2 monitor irq enable, bit 3 monitor flag
  localparam int GIE_BIT = 0;
  localparam int GRP_EN_BIT = 1;
  localparam int MON_IE_BIT = 2;
  localparam int MON_FLAG_BIT = 3;
  localparam logic [7:0] SUPPLY_MON_RESET = 8'h00;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int FLAG_SET_DELAY_US = 15;
  localparam int STAB_DELAY_US = 30;
  localparam int FLAG_SET_CYC = (FLAG_SET_DELAY_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                FLAG_SET_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int STAB_CYC = (STAB_DELAY_US * (CLK_HZ / 1_000_000) < 1) ? 1 : STAB_DELAY_US * (CLK_HZ / 1_000_000);
  localparam logic [9:0] FLAG_SET_CNT = 10'(FLAG_SET_CYC);
  localparam logic [9:0] STAB_CNT = 10'(STAB_CYC);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Core sequencer requests
  typedef struct packed {
    logic service;
    logic return_from_interrupt_instr;
    logic ret;
    logic stack_full;
    logic sleep;
  } iwl_core_req_s;
  // Entry answer towards the core
  typedef struct packed {
    logic vector_call;
    logic push_pc;
  } iwl_core_ans_s;
  typedef enum logic [1:0] {
    IWL_RD_IDLE = 2'b00,
    IWL_RD_RESP = 2'b01
  } iwl_rd_e;
endpackage

// >>> iwl_core_model.sv
// Partner model: core sequencer that requests service, returns and sleeps
module iwl_core_model (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire iwl_pkg::iwl_core_ans_s core_ans, // Entry answer from the block
  output iwl_pkg::iwl_core_req_s core_req // Sequencer requests
);
  import iwl_pkg::*;
  int calls = 0;
  int pushes = 0;
  initial core_req = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Count entries; one pushed word per entry, the program counter only
  always @(posedge ref_clk) begin
    if (rst) begin
      calls <= 0;
      pushes <= 0;
    end else begin
      if (core_ans.vector_call === 1'b1) begin
        calls <= calls + 1;
        core_req.service <= 1'b0; // A vectored core stops asking until told again
      end
      if (core_ans.push_pc === 1'b1) begin
        pushes <= pushes + 1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Levels change just after an edge so the block samples them cleanly
  task automatic set_req(input logic svc, input logic full, input logic slp);
    @(posedge ref_clk);
    core_req.service <= svc;
    core_req.stack_full <= full;
    core_req.sleep <= slp;
  endtask
  // Leave the service routine, with or without re-enabling
  task automatic do_return(input logic with_gie);
    @(posedge ref_clk);
    core_req.return_from_interrupt_instr <= with_gie;
    core_req.ret <= ~with_gie;
    @(posedge ref_clk);
    core_req.return_from_interrupt_instr <= 1'b0;
    core_req.ret <= 1'b0;
  endtask
endmodule

// >>> iwl_top_tb.sv
// Testbench: register, flag, entry, wake and supply-monitor scenarios
module iwl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iwl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_TM-1:0] period_match = '0;
  logic [NUM_TM-1:0] compare_a_match = '0;
  logic supply_low_raw = 1'b0;
  iwl_core_req_s core_req;
  iwl_core_ans_s core_ans;
  logic wake_up;
  logic monitor_on;
  logic [2:0] threshold_sel;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [7:0] en_tab [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
  logic [7:0] ctl_tab [4] = '{8'h03, 8'h02, 8'h01, 8'h03};
  int fail_count = 0;
  int checked = 0;
  int wake_cnt = 0;

  always #50 ref_clk = ~ref_clk;

  iwl_top i_dut (.ref_clk, .rst, .period_match, .compare_a_match, .supply_low_raw, .core_req, .core_ans,
    .wake_up, .monitor_on, .threshold_sel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  iwl_core_model i_core (.ref_clk, .rst, .core_ans, .core_req);

  // Wake pulses last one cycle, so count them at every edge
  always @(posedge ref_clk) begin
    if (wake_up === 1'b1) wake_cnt <= wake_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bus master: hold each channel until taken; an extra edge keeps strobes apart
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
    if (n >= 40) chk(32'h0, 32'h1, "write hang");
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
    if (n >= 40) chk(32'h0, 32'h1, "read hang");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_rd(a);
    chk(rd_data, exp, what);
  endtask
  task automatic pulse(input logic [NUM_TM-1:0] p, input logic [NUM_TM-1:0] c);
    @(posedge ref_clk);
    period_match <= p;
    compare_a_match <= c;
    @(posedge ref_clk);
    period_match <= '0;
    compare_a_match <= '0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(REG_SUPPLY_MON, 32'h00, "monitor reset");
    axi_wr(REG_SUPPLY_MON, 32'hff);
    rd_chk(REG_SUPPLY_MON, 32'h17, "unused bits");
    for (int t = 0; t < 8; t++) begin
      axi_wr(REG_SUPPLY_MON, 32'h10 + 32'(t));
      chk(32'({monitor_on, threshold_sel}), 32'h8 + 32'(t), "threshold");
    end
    axi_wr(REG_SUPPLY_MON, 32'h07);
    chk(32'(monitor_on), 32'h0, "monitor off");
    axi_rd(8'h14);
    chk({rd_data[29:0], resp}, 32'(RESP_SLVERR), "unmapped read");
    axi_wr(8'h14, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    // Flags set with every enable off and stay until cleared
    pulse(4'h5, 4'ha);
    rd_chk(REG_TM_FLAGS, 32'ha5, "match flags");
    axi_wr(REG_TM_FLAGS, 32'h0);
    rd_chk(REG_TM_FLAGS, 32'h0, "flags cleared");
    i_core.set_req(1'b0, 1'b0, 1'b1);
    pulse(4'h0, 4'h4);
    repeat (4) @(posedge ref_clk);
    chk(32'(wake_cnt), 32'd1, "wake on rise");
    pulse(4'h0, 4'h4);
    repeat (4) @(posedge ref_clk);
    chk(32'(wake_cnt), 32'd1, "flag already high");
    axi_wr(REG_TM_FLAGS, 32'h0);
    i_core.set_req(1'b0, 1'b0, 1'b0);
    pulse(4'h1, 4'h0);
    // Each missing enable, or a full stack, alone must block the vector call
    for (int c = 0; c < 4; c++) begin
      axi_wr(REG_TM_ENABLES, 32'(en_tab[c]));
      axi_wr(REG_CORE_CTRL, 32'(ctl_tab[c]));
      i_core.set_req(1'b1, c == 3, 1'b0);
      repeat (6) @(posedge ref_clk);
      chk(32'(i_core.calls), 32'd0, "entry blocked");
      i_core.set_req(1'b0, 1'b0, 1'b0);
    end
    i_core.set_req(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge ref_clk);
    chk(32'(i_core.calls), 32'd1, "entry");
    chk(32'(i_core.pushes), 32'd1, "one push");
    rd_chk(REG_CORE_CTRL, 32'h02, "global enable cleared");
    rd_chk(REG_STATUS, 32'h00, "group flag cleared");
    rd_chk(REG_TM_FLAGS, 32'h01, "source flag kept");
    i_core.do_return(1'b1);
    rd_chk(REG_CORE_CTRL, 32'h03, "return with enable");
    // A fresh request is needed to arm the group again
    axi_wr(REG_TM_FLAGS, 32'h0);
    pulse(4'h1, 4'h0);
    rd_chk(REG_STATUS, 32'h01, "group flag rearmed");
    i_core.set_req(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge ref_clk);
    chk(32'(i_core.calls), 32'd2, "second entry");
    i_core.do_return(1'b0);
    rd_chk(REG_CORE_CTRL, 32'h02, "plain return");
    axi_wr(REG_TM_FLAGS, 32'h0);
    axi_wr(REG_TM_ENABLES, 32'h0);
    // Supply monitor in sleep: wait to settle, clear its flag, then dip twice
    i_core.set_req(1'b0, 1'b0, 1'b1);
    axi_wr(REG_SUPPLY_MON, 32'h13);
    repeat (STAB_CYC + 20) @(posedge ref_clk);
    axi_rd(REG_STATUS);
    chk(rd_data & 32'h2, 32'h2, "detector settled");
    axi_wr(REG_CORE_CTRL, 32'h0);
    supply_low_raw <= 1'b1;
    repeat (100) @(posedge ref_clk);
    rd_chk(REG_SUPPLY_MON, 32'h33, "detector low");
    supply_low_raw <= 1'b0;
    repeat (10) @(posedge ref_clk);
    supply_low_raw <= 1'b1;
    repeat (100) @(posedge ref_clk);
    rd_chk(REG_CORE_CTRL, 32'h00, "delay restarts");
    repeat (80) @(posedge ref_clk);
    rd_chk(REG_CORE_CTRL, 32'h08, "flag after delay");
    chk(32'(wake_cnt), 32'd2, "monitor wake");
    supply_low_raw <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd_chk(REG_SUPPLY_MON, 32'h13, "detector high");
    print_verdict;
  end
  // Watchdog well beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    chk(32'h0, 32'h1, "watchdog");
    print_verdict;
  end
endmodule
